// >>> verilog/lcm_defines.vh
// Operation
// - Link-channel enable 0 puts transmit HDLC on data link, 1 on timeslots.
// - Mode 0 takes one timeslot number from bits 4..0, bit 4 MSB.
// - Mode 1 ignores channel number and uses per-channel block selects.
// - Each suppress bit set stops that timeslot bit carrying HDLC data.
// - HDLC may serve a timeslot while legacy path serves the data link.
// - Legacy receive capture and HDLC receive run together independently.
// - Each kept data-link or Fs bit shifts into an 8-bit receive register.
// - Each full byte sets the receive-link-full status flag.
// - Full flag with its mask enabled drives interrupt low.
// - Completed byte equal to either match byte sets the match flag.
// - Match flag with its mask enabled drives interrupt low.
// - Destuffer enabled deletes a zero after exactly five ones.
// - A zero after six or more ones passes through unchanged.
// - First received bit lands in bit 0, last in bit 7.
// - Two 8-bit match registers at 0x29 and 0x2a compare each byte.
`ifndef LCM_DEFINES_VH
`define LCM_DEFINES_VH
`define LCM_ADDR_RX_BYTE     8'h28
`define LCM_ADDR_MATCH_ONE   8'h29
`define LCM_ADDR_MATCH_TWO   8'h2a
`define LCM_ADDR_TX_CTRL     8'h92
`define LCM_ADDR_TX_SUPP     8'h93
`define LCM_TX_CTRL_ENABLE   7
`define LCM_TX_CTRL_MODE     5
`define LCM_TX_CTRL_NUM_HI   4
`define LCM_TX_CTRL_NUM_LO   0
`define LCM_CTRL_WMASK       8'hbf
`define LCM_RESET_BYTE       8'h00
`define LCM_BITS_PER_BYTE    4'h8
`define LCM_ONES_STUFF       3'h5
`define LCM_ONES_MAX         3'h6
`define LCM_NUM_CHANNELS     24
`endif

// >>> verilog/lcm_destuff.v
`timescale 1ns/10ps
`default_nettype none
`include "lcm_defines.vh"
module lcm_destuff (
   input  wire       clock_i,
   input  wire       rst_n_i,
   input  wire       enable_i,
   input  wire       bit_valid_i,
   input  wire       bit_i,
   output wire       keep_o
);
   reg  [2:0] ones_run;
   // Saturate at six so longer runs stay distinguishable from exactly five
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ones_run <= 3'h0;
      end else if (bit_valid_i) begin
         if (!bit_i)
            ones_run <= 3'h0;
         else if (ones_run != `LCM_ONES_MAX)
            ones_run <= ones_run + 3'h1;
      end
   end
   // Drop only the zero after exactly five ones
   assign keep_o = !(enable_i && !bit_i && (ones_run == `LCM_ONES_STUFF));
endmodule // lcm_destuff
`default_nettype wire

// >>> verilog/lcm_tx_map.v
`timescale 1ns/10ps
`default_nettype none
`include "lcm_defines.vh"
module lcm_tx_map (
   input  wire [7:0]  ctrl_i,
   input  wire [7:0]  suppress_i,
   input  wire [23:0] block_sel_i,
   input  wire [4:0]  channel_i,
   input  wire [2:0]  bit_pos_i,
   output wire        on_link_o,
   output wire        hdlc_bit_o
);
   wire       ts_en = ctrl_i[`LCM_TX_CTRL_ENABLE];
   wire       mode  = ctrl_i[`LCM_TX_CTRL_MODE];
   wire [4:0] num   = ctrl_i[`LCM_TX_CTRL_NUM_HI:`LCM_TX_CTRL_NUM_LO];
   wire [23:0] sel_vec;
   genvar g;
   // Per-channel selection, single number or block vector
   generate
      for (g = 0; g < `LCM_NUM_CHANNELS; g = g + 1) begin : g_ch
         localparam [4:0] CH_NUM = g;
         assign sel_vec[g] = mode ? block_sel_i[g] : (num == CH_NUM);
      end
   endgenerate
   wire in_range = (channel_i < 5'h18);
   assign on_link_o = !ts_en;
   // Bit position 0 is the timeslot MSB, bit 7 its LSB
   assign hdlc_bit_o = ts_en && in_range && sel_vec[channel_i]
                       && !suppress_i[3'h7 - bit_pos_i];
endmodule // lcm_tx_map
`default_nettype wire

// >>> verilog/lcm_link_channel.v
`timescale 1ns/10ps
`default_nettype none
`include "lcm_defines.vh"
module lcm_link_channel (
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Host parallel port
   input  wire [7:0]  addr_i,
   input  wire [7:0]  wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [7:0]  rdata_o,
   // Status, mask and destuff controls held elsewhere in the device
   input  wire        rx_link_full_irq_en_i,
   input  wire        rx_link_match_irq_en_i,
   input  wire        zero_destuff_enable_i,
   input  wire        full_flag_clear_i,
   input  wire        match_flag_clear_i,
   output reg         rx_link_full_flag_o,
   output reg         rx_link_match_flag_o,
   output wire        int_n_o,
   // Receive data-link bit stream from the framer
   input  wire        rx_bit_valid_i,
   input  wire        rx_bit_i,
   // Transmit timeslot position and block selects
   input  wire [23:0] tx_channel_block_select_i,
   input  wire [4:0]  tx_channel_i,
   input  wire [2:0]  tx_bit_pos_i,
   output wire        tx_hdlc_on_link_o,
   output wire        tx_hdlc_bit_o
);
   ////////////////////////////////////////////////////////////////////////
   reg  [7:0] tx_link_channel_control;
   reg  [7:0] tx_link_bit_suppress;
   reg  [7:0] rx_link_match_one;
   reg  [7:0] rx_link_match_two;
   reg  [7:0] rx_link_byte;
   reg  [7:0] shift_reg;
   reg  [3:0] bit_count;
   wire       keep_bit;
   wire [7:0] next_shift;
   wire       byte_done;

   // Host register writes
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         tx_link_channel_control <= `LCM_RESET_BYTE;
         tx_link_bit_suppress    <= `LCM_RESET_BYTE;
         rx_link_match_one       <= `LCM_RESET_BYTE;
         rx_link_match_two       <= `LCM_RESET_BYTE;
      end else if (wr_i) begin
         case (addr_i)
            `LCM_ADDR_TX_CTRL:   tx_link_channel_control <= wdata_i & `LCM_CTRL_WMASK;
            `LCM_ADDR_TX_SUPP:   tx_link_bit_suppress    <= wdata_i;
            `LCM_ADDR_MATCH_ONE: rx_link_match_one       <= wdata_i;
            `LCM_ADDR_MATCH_TWO: rx_link_match_two       <= wdata_i;
            default: ;
         endcase
      end
   end

   // Registered read data, unmapped reads return zero
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `LCM_ADDR_RX_BYTE:   rdata_o <= rx_link_byte;
            `LCM_ADDR_MATCH_ONE: rdata_o <= rx_link_match_one;
            `LCM_ADDR_MATCH_TWO: rdata_o <= rx_link_match_two;
            `LCM_ADDR_TX_CTRL:   rdata_o <= tx_link_channel_control;
            `LCM_ADDR_TX_SUPP:   rdata_o <= tx_link_bit_suppress;
            default:             rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive path runs regardless of HDLC receive use
   lcm_destuff u_destuff (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .enable_i    (zero_destuff_enable_i),
      .bit_valid_i (rx_bit_valid_i),
      .bit_i       (rx_bit_i),
      .keep_o      (keep_bit)
   );

   // LSB-first: new bit enters at the top and moves down
   assign next_shift = {rx_bit_i, shift_reg[7:1]};
   assign byte_done  = rx_bit_valid_i && keep_bit
                       && (bit_count == `LCM_BITS_PER_BYTE - 4'h1);

   // Shift kept bits, count to eight
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         shift_reg <= 8'h00;
         bit_count <= 4'h0;
      end else if (rx_bit_valid_i && keep_bit) begin
         shift_reg <= next_shift;
         bit_count <= byte_done ? 4'h0 : bit_count + 4'h1;
      end
   end

   // Whole byte moves at once; old byte lost if unread
   always @(posedge clock_i) begin
      if (!rst_n_i)
         rx_link_byte <= `LCM_RESET_BYTE;
      else if (byte_done)
         rx_link_byte <= next_shift;
   end

   // Sticky flags, a new event wins over a clear in the same cycle
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         rx_link_full_flag_o  <= 1'b0;
         rx_link_match_flag_o <= 1'b0;
      end else begin
         if (byte_done)
            rx_link_full_flag_o <= 1'b1;
         else if (full_flag_clear_i)
            rx_link_full_flag_o <= 1'b0;
         if (byte_done && (next_shift == rx_link_match_one ||
                           next_shift == rx_link_match_two))
            rx_link_match_flag_o <= 1'b1;
         else if (match_flag_clear_i)
            rx_link_match_flag_o <= 1'b0;
      end
   end

   // Active-low interrupt, gated by masks
   assign int_n_o = !((rx_link_full_flag_o && rx_link_full_irq_en_i) ||
                      (rx_link_match_flag_o && rx_link_match_irq_en_i));

   ////////////////////////////////////////////////////////////////////////
   // Transmit mapping; legacy link path stays free when on timeslots
   lcm_tx_map u_tx_map (
      .ctrl_i      (tx_link_channel_control),
      .suppress_i  (tx_link_bit_suppress),
      .block_sel_i (tx_channel_block_select_i),
      .channel_i   (tx_channel_i),
      .bit_pos_i   (tx_bit_pos_i),
      .on_link_o   (tx_hdlc_on_link_o),
      .hdlc_bit_o  (tx_hdlc_bit_o)
   );
endmodule // lcm_link_channel
`default_nettype wire

// >>> tb/lcm_link_channel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module lcm_link_channel_monitor (
   input wire logic       clock_i,
   input wire logic       rst_n_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       rx_link_full_irq_en_i,
   input wire logic       rx_link_match_irq_en_i,
   input wire logic       full_flag_clear_i,
   input wire logic       rx_link_full_flag_o,
   input wire logic       rx_link_match_flag_o,
   input wire logic       int_n_o,
   input wire logic       rx_bit_valid_i,
   input wire logic [4:0] tx_channel_i,
   input wire logic       tx_hdlc_on_link_o,
   input wire logic       tx_hdlc_bit_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Interrupt follows enabled flags
   full_irq_a: assert property (
      rx_link_full_flag_o && rx_link_full_irq_en_i |-> !int_n_o) else $error("full irq");
   match_irq_a: assert property (
      rx_link_match_flag_o && rx_link_match_irq_en_i |-> !int_n_o) else $error("match irq");
   // Flags rise only after a valid bit; full flag sticks until cleared
   full_rise_a: assert property (
      $rose(rx_link_full_flag_o) |-> $past(rx_bit_valid_i)) else $error("full rise");
   match_rise_a: assert property (
      $rose(rx_link_match_flag_o) |-> $past(rx_bit_valid_i)) else $error("match rise");
   full_hold_a: assert property (
      rx_link_full_flag_o && !full_flag_clear_i |=> rx_link_full_flag_o) else $error("full lost");
   rdata_hold_a: assert property (
      !rd_i |=> $stable(rdata_o)) else $error("rdata moved");
   // Transmit map exclusivity
   on_link_a: assert property (
      tx_hdlc_on_link_o |-> !tx_hdlc_bit_o) else $error("link and slot");
   chan_range_a: assert property (
      tx_channel_i > 5'h17 |-> !tx_hdlc_bit_o) else $error("bad channel");
endmodule // lcm_link_channel_monitor
bind lcm_link_channel lcm_link_channel_monitor u_lcm_link_channel_monitor (.clock_i, .rst_n_i,
   .rd_i, .rdata_o, .rx_link_full_irq_en_i, .rx_link_match_irq_en_i, .full_flag_clear_i,
   .rx_link_full_flag_o, .rx_link_match_flag_o, .int_n_o, .rx_bit_valid_i, .tx_channel_i,
   .tx_hdlc_on_link_o, .tx_hdlc_bit_o);
`default_nettype wire

// >>> tb/lcm_framer_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcm_framer_model (
   input  wire logic clock_i,
   output var  logic valid_o,
   output var  logic bit_o
);
   initial valid_o = 1'b0;
   initial bit_o = 1'b0;
   // LSB first, random gaps; idle line shows inverse of last bit
   task automatic send(input logic [15:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         repeat ($urandom % 3) @(negedge clock_i);
         valid_o = 1'b1;
         bit_o = b[i];
         @(negedge clock_i);
         valid_o = 1'b0;
         bit_o = ~bit_o;
      end
   endtask
endmodule // lcm_framer_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, ctl, sup, m1, m2, x;
   logic        fen = 1'b0, men = 1'b0, dse = 1'b0, fclr = 1'b0, mclr = 1'b0;
   logic        ff, mf, int_n, vld, rbit, on_link, hbit;
   logic [23:0] blk = 24'h000000;
   logic [4:0]  ch = 5'h00;
   logic [2:0]  pos = 3'h0;
   int          bad_count = 0, checked = 0;
   initial forever #20 clk = ~clk;
   lcm_framer_model u_lcm_framer_model (.clock_i(clk), .valid_o(vld), .bit_o(rbit));
   lcm_link_channel u_lcm_link_channel (.clock_i(clk), .rst_n_i(rst_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_link_full_irq_en_i(fen),
      .rx_link_match_irq_en_i(men), .zero_destuff_enable_i(dse), .full_flag_clear_i(fclr),
      .match_flag_clear_i(mclr), .rx_link_full_flag_o(ff), .rx_link_match_flag_o(mf),
      .int_n_o(int_n), .rx_bit_valid_i(vld), .rx_bit_i(rbit), .tx_channel_block_select_i(blk),
      .tx_channel_i(ch), .tx_bit_pos_i(pos), .tx_hdlc_on_link_o(on_link), .tx_hdlc_bit_o(hbit));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Host port cycles, entered just after a falling edge
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("rdata", e, rdata);
      @(negedge clk);
   endtask
   // One received byte, then flags cleared for the next
   task automatic rx(input logic [15:0] b, input int n, input logic [7:0] e);
      u_lcm_framer_model.send(b, n);
      chk("full", 8'h01, {7'h00, ff});
      chk("match", {7'h00, e == m1 || e == m2}, {7'h00, mf});
      chk("int_n", {7'h00, !(fen || men && (e == m1 || e == m2))}, {7'h00, int_n});
      rreg(8'h28, e);
      fclr = 1'b1;
      mclr = 1'b1;
      @(negedge clk);
      fclr = 1'b0;
      mclr = 1'b0;
      chk("clear", 8'h00, {6'h00, ff, mf});
   endtask
   function automatic logic hx(input logic [7:0] c, s, input logic [4:0] n, input logic [2:0] p);
      if (!c[7] || n > 5'h17 || s[3'h7 - p])
         return 1'b0;
      return c[5] ? blk[n] : (n == c[4:0]);
   endfunction
   initial begin
      #400000;
      bad_count++;
      summarize;
   end
   // Main sequence
   initial begin
      void'($urandom(90048));
      m1 = 8'h00;
      m2 = 8'h00;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      rreg(8'h92, 8'h00);
      rreg(8'h77, 8'h00);
      dse = 1'b1;
      fen = 1'b1;
      rx(16'h009f, 9, 8'h5f);
      rx(16'h00bf, 8, 8'hbf);
      dse = 1'b0;
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      wreg(8'h29, m1);
      wreg(8'h2a, m2);
      wreg(8'h28, 8'hff);
      rreg(8'h28, 8'hbf);
      rreg(8'h2a, m2);
      for (int i = 0; i < 6; i++) begin
         fen = 1'($urandom);
         men = 1'($urandom);
         x = (i == 0) ? m1 : (i == 1) ? m2 : 8'($urandom);
         rx({8'h00, x}, 8, x);
      end
      for (int i = 0; i < 60; i++) begin
         ctl = 8'($urandom);
         sup = 8'($urandom);
         blk = 24'($urandom);
         ch = (i % 2) ? ctl[4:0] : 5'($urandom);
         pos = 3'($urandom);
         wreg(8'h92, ctl);
         wreg(8'h93, sup);
         rreg(8'h92, ctl & 8'hbf);
         chk("link", {7'h00, !ctl[7]}, {7'h00, on_link});
         chk("hdlc", {7'h00, hx(ctl, sup, ch, pos)}, {7'h00, hbit});
      end
      summarize;
   end
endmodule // testbench
`default_nettype wire
